//--- core/ossm_pkg.sv
// Package for the oscillator source select and monitor block.
// Assumes a 20 MHz system clock and an AXI4-Lite master with 32-bit data.
package ossm_pkg;

  // ------------------------------
  // Register map
  // ------------------------------
  localparam logic [7:0] OSSM_OFS_STATUS    = 8'h00;
  localparam logic [7:0] OSSM_OFS_CTRL      = 8'h04;
  localparam logic [7:0] OSSM_OFS_CONFIG    = 8'h08;
  localparam logic [7:0] OSSM_OFS_EVT       = 8'h0C;
  localparam logic [7:0] OSSM_OFS_MASK      = 8'h10;
  localparam logic [7:0] OSSM_OFS_ACTIVE    = 8'h14;

  // ------------------------------
  // Status bit positions
  // ------------------------------
  localparam int OSSM_BIT_EXT   = 7;
  localparam int OSSM_BIT_HF    = 6;
  localparam int OSSM_BIT_MF    = 5;
  localparam int OSSM_BIT_LF    = 4;
  localparam int OSSM_BIT_SEC   = 3;
  localparam int OSSM_BIT_CONV  = 2;
  localparam int OSSM_BIT_PLL   = 0;

  // Event bit positions.
  localparam int OSSM_EVT_FAIL   = 0;
  localparam int OSSM_EVT_SWITCH = 1;
  localparam int OSSM_EVT_XTAL   = 2;
  localparam int OSSM_EVT_W      = 3;

  // ------------------------------
  // Source and mode codes
  // ------------------------------
  localparam logic [2:0] OSSM_SRC_LF      = 3'h0;
  localparam logic [2:0] OSSM_SRC_HF_1M   = 3'h1;
  localparam logic [2:0] OSSM_SRC_HF_32M  = 3'h2;
  localparam logic [2:0] OSSM_SRC_EXT     = 3'h3;

  localparam logic [2:0] OSSM_EXT_LOGIC_LOW  = 3'h0;
  localparam logic [2:0] OSSM_EXT_LOGIC_MED  = 3'h1;
  localparam logic [2:0] OSSM_EXT_LOGIC_HIGH = 3'h2;
  localparam logic [2:0] OSSM_EXT_XTAL_LOW   = 3'h3;
  localparam logic [2:0] OSSM_EXT_XTAL_MED   = 3'h4;
  localparam logic [2:0] OSSM_EXT_XTAL_HIGH  = 3'h5;

  // ------------------------------
  // Timing
  // ------------------------------
  localparam int OSSM_CLK_HZ           = 20000000;
  localparam int OSSM_STARTUP_EDGES    = 1024;
  localparam int OSSM_FAIL_TIMEOUT_US  = 100;
  localparam int OSSM_FAIL_CYCLES      = OSSM_FAIL_TIMEOUT_US * (OSSM_CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    OSSM_SW_IDLE,
    OSSM_SW_WAIT,
    OSSM_SW_COMMIT
  } ossm_sw_state_t;

endpackage

//--- core/ossm_sync.sv
// Two-flip-flop synchroniser for a single level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module ossm_sync
  import ossm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

//--- core/ossm_edge_watch.sv
// Watches a synchronised external clock level: counts its edges for start-up
// qualification and flags loss of activity.
// Assumes the input is already synchronised to clk.
`timescale 1ns/100ps
module ossm_edge_watch
  import ossm_pkg::*;
#(
  parameter int STARTUP_EDGES = OSSM_STARTUP_EDGES,
  parameter int FAIL_CYCLES   = OSSM_FAIL_CYCLES
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic need_startup,
  input  wire logic ext_level,
  output logic      stable,
  output logic      failed
);
  logic                             prev_r;
  logic [$clog2(STARTUP_EDGES+1)-1:0] edges_r;
  logic [$clog2(FAIL_CYCLES+1)-1:0]   idle_r;
  logic                             toggle;

  assign toggle = ext_level ^ prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= ext_level;
    end
  end

  // Crystals need the full count of edges; logic clocks are usable at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edges_r <= '0;
      stable  <= 1'b0;
    end else if (!enable || failed) begin
      edges_r <= '0;
      stable  <= 1'b0;
    end else if (!need_startup) begin
      stable  <= 1'b1;
    end else if (toggle && !stable) begin
      if (edges_r == ($bits(edges_r))'(STARTUP_EDGES - 1)) begin
        stable <= 1'b1;
      end
      edges_r <= edges_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_r <= '0;
      failed <= 1'b0;
    end else if (!enable) begin
      idle_r <= '0;
      failed <= 1'b0;
    end else if (toggle || !stable) begin
      // A starting crystal may be silent longer than the failure window, so only a qualified source is judged.
      idle_r <= '0;
    end else if (idle_r == ($bits(idle_r))'(FAIL_CYCLES - 1)) begin
      failed <= 1'b1;
    end else begin
      idle_r <= idle_r + 1'b1;
    end
  end
endmodule

//--- core/ossm_top.sv
// Oscillator source selection, start-up qualification and clock failure monitor.
// Assumes an AXI4-Lite master on sys_clk and raw oscillator inputs from pins.
// Function
// - At every reset the initial source is taken from the reset clock select field.
// - The reset field offers the low internal oscillator, the high one at 1 MHz or at 32 MHz, or the external source.
// - When an external source is chosen, the external mode field picks its mode.
// - Three external modes are logic clocks: below 500 kHz, 500 kHz to 8 MHz, above 8 MHz.
// - Three external modes are crystals: 32 kHz, 100 kHz to 4 MHz, and above 4 MHz.
// - Software can switch the system clock between external and internal sources.
// - The internal block provides low and high frequency clocks with selectable speeds.
// - Loss of the external clock in any external mode falls back to the internal oscillator.
// - Crystal sources are qualified by a start-up edge count before being usable.
// - Each ready bit reads one when its oscillator is usable, zero otherwise.
// - Status bits 7 to 2 report external, high, mid, low, secondary, converter; bit 0 PLL; bit 1 zero.
`timescale 1ns/100ps
module ossm_top
  import ossm_pkg::*;
#(
  parameter int STARTUP_EDGES = OSSM_STARTUP_EDGES,
  parameter int FAIL_CYCLES   = OSSM_FAIL_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  reset_clock_select,
  input  wire logic [2:0]  external_clock_mode_select,
  input  wire logic        ext_clk_in,
  input  wire logic        hf_osc_ok,
  input  wire logic        mf_osc_ok,
  input  wire logic        lf_osc_ok,
  input  wire logic        sec_osc_ok,
  input  wire logic        conv_osc_ok,
  input  wire logic        pll_lock,
  output logic [2:0]       sys_clk_source,
  output logic             hf_speed_32m,
  output logic             ext_enable,
  output logic [2:0]       ext_mode,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ------------------------------
  // Pin synchronisers
  // ------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {ext_clk_in, hf_osc_ok, mf_osc_ok, lf_osc_ok, sec_osc_ok, conv_osc_ok, pll_lock};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      ossm_sync u_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   (pin_raw[gi]),
        .q   (pin_s[gi])
      );
    end
  endgenerate

  logic ext_lvl;
  logic hf_ok;
  logic mf_ok;
  logic lf_ok;
  logic sec_ok;
  logic conv_ok;
  logic pll_ok;
  assign {ext_lvl, hf_ok, mf_ok, lf_ok, sec_ok, conv_ok, pll_ok} = pin_s;

  // ---------------------------------------------------------------------------
  // Configuration captured after reset release
  // ---------------------------------------------------------------------------
  // Straps are caught by a clocked process on the first edge after release.
  logic       cfg_done_r;
  logic [2:0] cfg_src_r;
  logic [2:0] cfg_mode_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_done_r <= 1'b0;
      cfg_src_r  <= OSSM_SRC_LF;
      cfg_mode_r <= OSSM_EXT_LOGIC_LOW;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      cfg_src_r  <= (reset_clock_select > OSSM_SRC_EXT) ? OSSM_SRC_LF : reset_clock_select;
      cfg_mode_r <= (external_clock_mode_select > OSSM_EXT_XTAL_HIGH) ?
                    OSSM_EXT_LOGIC_LOW : external_clock_mode_select;
    end
  end

  // ------------------------------
  // Register state
  // ------------------------------
  logic [2:0]           req_src_r;
  logic [2:0]           req_src_nxt;
  logic                 req_pend_r;
  logic [OSSM_EVT_W-1:0] evt_r;
  logic [OSSM_EVT_W-1:0] mask_r;
  logic [7:0]           status;

  // ---------------------------------------------------------------------------
  // External oscillator watch
  // ---------------------------------------------------------------------------
  logic ext_stable;
  logic ext_failed;
  logic need_startup;

  // Only crystal modes need the start-up count; a logic clock is trusted as soon as it is enabled.
  assign need_startup = (ext_mode >= OSSM_EXT_XTAL_LOW);

  ossm_edge_watch #(
    .STARTUP_EDGES (STARTUP_EDGES),
    .FAIL_CYCLES   (FAIL_CYCLES)
  ) u_watch (
    .clk          (sys_clk),
    .rst          (sys_rst),
    .enable       (ext_enable),
    .need_startup (need_startup),
    .ext_level    (ext_lvl),
    .stable       (ext_stable),
    .failed       (ext_failed)
  );

  // ------------------------------
  // Status register
  // ------------------------------
  always_comb begin
    status                 = 8'h00;
    status[OSSM_BIT_EXT]   = ext_stable & ~ext_failed;
    status[OSSM_BIT_HF]    = hf_ok;
    status[OSSM_BIT_MF]    = mf_ok;
    status[OSSM_BIT_LF]    = lf_ok;
    status[OSSM_BIT_SEC]   = sec_ok;
    status[OSSM_BIT_CONV]  = conv_ok;
    status[OSSM_BIT_PLL]   = pll_ok;
  end

  function automatic logic src_ready(input logic [2:0] s, input logic [7:0] st);
    logic r;
    r = 1'b0;
    unique case (s)
      OSSM_SRC_LF:     r = st[OSSM_BIT_LF];
      OSSM_SRC_HF_1M:  r = st[OSSM_BIT_HF];
      OSSM_SRC_HF_32M: r = st[OSSM_BIT_HF];
      OSSM_SRC_EXT:    r = st[OSSM_BIT_EXT];
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------------------
  ossm_sw_state_t sw_r;
  logic           fail_evt;
  logic           switch_evt;
  logic           xtal_evt;
  logic           ext_stable_d_r;

  assign fail_evt = ext_failed && (sys_clk_source == OSSM_SRC_EXT);
  assign xtal_evt = ext_stable && !ext_stable_d_r;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_stable_d_r <= 1'b0;
    end else begin
      ext_stable_d_r <= ext_stable;
    end
  end

  // Apart from the fall-back to 1 MHz on failure, the running clock changes only once the target reports ready, so no runt pulse is made.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_r           <= OSSM_SW_IDLE;
      sys_clk_source <= OSSM_SRC_LF;
      hf_speed_32m   <= 1'b0;
      ext_enable     <= 1'b0;
      ext_mode       <= OSSM_EXT_LOGIC_LOW;
      switch_evt     <= 1'b0;
    end else begin
      switch_evt <= 1'b0;
      if (!cfg_done_r) begin
        sw_r <= OSSM_SW_IDLE;
      end else if (fail_evt) begin
        sys_clk_source <= OSSM_SRC_HF_1M;
        hf_speed_32m   <= 1'b0;
        ext_enable     <= 1'b0;
        sw_r           <= OSSM_SW_IDLE;
        switch_evt     <= 1'b1;
      end else begin
        unique case (sw_r)
          OSSM_SW_IDLE: begin
            if (req_pend_r && req_src_r != sys_clk_source) begin
              ext_mode   <= cfg_mode_r;
              ext_enable <= ext_enable | (req_src_r == OSSM_SRC_EXT);
              sw_r       <= OSSM_SW_WAIT;
            end
          end
          OSSM_SW_WAIT: begin
            if (src_ready(req_src_r, status)) begin
              sw_r <= OSSM_SW_COMMIT;
            end
          end
          OSSM_SW_COMMIT: begin
            sys_clk_source <= req_src_r;
            hf_speed_32m   <= (req_src_r == OSSM_SRC_HF_32M);
            ext_enable     <= (req_src_r == OSSM_SRC_EXT);
            switch_evt     <= 1'b1;
            sw_r           <= OSSM_SW_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------
  // AXI4-Lite slave
  // ------------------------------
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_ok;
  logic [31:0] rd_val;
  logic        rd_ok;

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ok = (aw_addr_r <= OSSM_OFS_ACTIVE);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign req_src_nxt = (w_data_r[2:0] > OSSM_SRC_EXT) ? sys_clk_source : w_data_r[2:0];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_src_r  <= OSSM_SRC_LF;
      req_pend_r <= 1'b0;
    end else if (!cfg_done_r) begin
      req_src_r  <= (reset_clock_select > OSSM_SRC_EXT) ? OSSM_SRC_LF : reset_clock_select;
      req_pend_r <= 1'b1;
    end else if (wr_go && aw_addr_r == OSSM_OFS_CTRL && w_strb_r[0]) begin
      req_src_r  <= req_src_nxt;
      req_pend_r <= 1'b1;
    end else if (sw_r == OSSM_SW_COMMIT || fail_evt) begin
      req_pend_r <= 1'b0;
    end
  end

  // Sticky events: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_r  <= '0;
      mask_r <= '0;
    end else begin
      if (wr_go && aw_addr_r == OSSM_OFS_MASK && w_strb_r[0]) begin
        mask_r <= w_data_r[OSSM_EVT_W-1:0];
      end
      evt_r <= (evt_r & ~((wr_go && aw_addr_r == OSSM_OFS_EVT && w_strb_r[0]) ?
                          w_data_r[OSSM_EVT_W-1:0] : '0))
             | {xtal_evt, switch_evt, fail_evt};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_r & mask_r);
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      OSSM_OFS_STATUS: rd_val[7:0] = status;
      OSSM_OFS_CTRL:   rd_val[2:0] = req_src_r;
      OSSM_OFS_CONFIG: rd_val[6:0] = {cfg_mode_r, 1'b0, cfg_src_r};
      OSSM_OFS_EVT:    rd_val[OSSM_EVT_W-1:0] = evt_r;
      OSSM_OFS_MASK:   rd_val[OSSM_EVT_W-1:0] = mask_r;
      OSSM_OFS_ACTIVE: rd_val[5:0] = {ext_failed, sw_r != OSSM_SW_IDLE, hf_speed_32m, sys_clk_source};
      default:         rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- test/ossm_props.sv
// Checker for ossm_top: source codes, start-up and failure bounds, bus holds.
// Assumes it is bound into ossm_top and sees only that module's ports.
`timescale 1ns/100ps
module ossm_props
  import ossm_pkg::*;
#(
  parameter int STARTUP_EDGES = OSSM_STARTUP_EDGES,
  parameter int FAIL_CYCLES   = OSSM_FAIL_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        ext_clk_in,
  input  wire logic [2:0]  sys_clk_source,
  input  wire logic        hf_speed_32m,
  input  wire logic        ext_enable,
  input  wire logic [2:0]  ext_mode,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] raddr_r;
  logic       ext_d_r;
  int         still_r;
  int         edges_r;

  // ------------------------------
  // Helper counters
  // ------------------------------
  // Raw edges are counted, which can only run ahead of the synchronised count.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      raddr_r <= 8'h00;
      ext_d_r <= 1'h0;
      still_r <= 0;
      edges_r <= 0;
    end else begin
      ext_d_r <= ext_clk_in;
      if (s_axi_arvalid && s_axi_arready)
        raddr_r <= {s_axi_araddr[7:2], 2'h0};
      if (sys_clk_source == OSSM_SRC_EXT && ext_enable && ext_clk_in == ext_d_r)
        still_r <= still_r + 1;
      else
        still_r <= 0;
      if (!ext_enable)
        edges_r <= 0;
      else if (ext_clk_in != ext_d_r)
        edges_r <= edges_r + 1;
    end
  end

  // ------------------------------
  // Properties
  // ------------------------------
  property p_src_legal; sys_clk_source <= OSSM_SRC_EXT; endproperty
  a_src_legal: assert property (p_src_legal) else $error("source code out of range");
  property p_mode_legal; ext_enable |-> ext_mode <= OSSM_EXT_XTAL_HIGH; endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("external mode out of range");
  property p_ext_on; sys_clk_source == OSSM_SRC_EXT |-> ext_enable || $fell(ext_enable); endproperty
  a_ext_on: assert property (p_ext_on) else $error("external source selected while disabled");
  property p_hf32; sys_clk_source == OSSM_SRC_HF_32M |-> ##[0:1] hf_speed_32m; endproperty
  a_hf32: assert property (p_hf32) else $error("32 MHz speed not set");
  property p_fail_bound; still_r <= FAIL_CYCLES + 8; endproperty
  a_fail_bound: assert property (p_fail_bound) else $error("dead external clock still selected");
  property p_xtal_wait;
    sys_clk_source == OSSM_SRC_EXT && $past(sys_clk_source) != OSSM_SRC_EXT
      && ext_mode >= OSSM_EXT_XTAL_LOW |-> edges_r >= STARTUP_EDGES;
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("crystal selected before start-up");
  property p_stat_bits;
    s_axi_rvalid && raddr_r == OSSM_OFS_STATUS |-> s_axi_rdata[1] == 1'h0 && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("status reserved bits set");
  property p_unmapped; s_axi_rvalid && raddr_r > OSSM_OFS_ACTIVE |-> s_axi_rresp == 2'h2; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");

  c_xtal: cover property (sys_clk_source == OSSM_SRC_EXT && ext_mode == OSSM_EXT_XTAL_HIGH);
  c_fail: cover property ($fell(ext_enable));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind ossm_top ossm_props #(.STARTUP_EDGES(STARTUP_EDGES), .FAIL_CYCLES(FAIL_CYCLES)) u_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .ext_clk_in(ext_clk_in), .sys_clk_source(sys_clk_source),
  .hf_speed_32m(hf_speed_32m), .ext_enable(ext_enable), .ext_mode(ext_mode),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);

//--- test/ossm_ext_model.sv
// External clock source: a logic clock or a crystal that oscillates when enabled.
// Assumes run is held low by the bench to model a dead or not yet started source.
`timescale 1ns/100ps
module ossm_ext_model #(
  parameter int HALF_NS = 85
)(
  input  wire logic enable,
  input  wire logic run,
  output logic      clk_out
);
  // A disabled source rests low, so enabling it shows no false edge; a dead one holds its level.
  initial clk_out = 1'h0;
  always begin
    #(HALF_NS);
    if (!enable)
      clk_out = 1'h0;
    else if (run)
      clk_out = ~clk_out;
  end
endmodule

//--- test/testbench.sv
// Self-checking bench for ossm_top with short start-up and failure counts.
// Assumes ossm_props is bound in and the external model sits on ext_clk_in.
`timescale 1ns/100ps
module testbench
  import ossm_pkg::*;
;
  localparam int SE = 4;
  localparam int FC = 16;
  logic        sys_clk, sys_rst, ext_clk, ext_en, hf32, irq, run;
  logic [2:0]  rcs, logic_clock_medium_power, src, emode;
  logic [5:0]  ok;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          errors, check_count;

  ossm_top #(.STARTUP_EDGES(SE), .FAIL_CYCLES(FC)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_clock_select(rcs), .external_clock_mode_select(logic_clock_medium_power),
    .ext_clk_in(ext_clk), .hf_osc_ok(ok[5]), .mf_osc_ok(ok[4]), .lf_osc_ok(ok[3]), .sec_osc_ok(ok[2]),
    .conv_osc_ok(ok[1]), .pll_lock(ok[0]), .sys_clk_source(src), .hf_speed_32m(hf32),
    .ext_enable(ext_en), .ext_mode(emode), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ossm_ext_model u_ext (.enable(ext_en), .run(run), .clk_out(ext_clk));

  always #25 sys_clk = ~sys_clk;

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready is raised only once the answer stands, so the slave must hold it for a cycle.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (!bvalid && n < 100);
    bready <= 1'h1;
    @(posedge sys_clk);
    bready <= 1'h0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n = 0;
    {araddr, arvalid} <= {a, 1'h1};
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (!rvalid && n < 100);
    rready <= 1'h1;
    @(posedge sys_clk);
    d = rdata;
    rready <= 1'h0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    axr(a, d, 2'h0);
    chk(nm, e, d & m);
  endtask

  task automatic wsrc(input logic [2:0] s, input int lim);
    for (int n = 0; n < lim && src !== s; n++) @(posedge sys_clk);
    chk("source", {29'h0, s}, {29'h0, src});
  endtask

  task automatic boot(input logic [2:0] s, input logic [2:0] m);
    {rcs, logic_clock_medium_power, sys_rst} <= {s, m, 1'h1};
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs;
    logic [31:0] d;
    boot(3'h0, 3'h0);
    ok <= 6'h2D;
    axw(OSSM_OFS_STATUS, 32'hFF, 2'h0);
    axw(OSSM_OFS_CONFIG, 32'h77, 2'h0);
    rd("status", OSSM_OFS_STATUS, 32'hFFFFFFFF, 32'h59);
    ok <= 6'h12;
    repeat (4) @(posedge sys_clk);
    rd("status", OSSM_OFS_STATUS, 32'hFFFFFFFF, 32'h24);
    ok <= 6'h3F;
    rd("config", OSSM_OFS_CONFIG, 32'h77, 32'h0);
    rd("mask", OSSM_OFS_MASK, 32'hFF, 32'h0);
    axr(8'h18, d, 2'h2);
    axw(8'h18, 32'h1, 2'h2);
  endtask

  task automatic t_boot_int;
    for (int s = 0; s < 3; s++) begin
      boot(3'(s), 3'h0);
      wsrc(3'(s), 50);
      rd("config", OSSM_OFS_CONFIG, 32'h7, s);
      chk("hf32", {31'h0, s == 2}, {31'h0, hf32});
    end
  endtask

  task automatic t_boot_ext;
    run <= 1'h1;
    for (int m = 0; m < 6; m++) begin
      boot(OSSM_SRC_EXT, 3'(m));
      wsrc(OSSM_SRC_EXT, 200);
      chk("mode", m, {29'h0, emode});
      rd("config", OSSM_OFS_CONFIG, 32'h77, (m << 4) | 3);
      rd("event", OSSM_OFS_EVT, 32'h1 << OSSM_EVT_XTAL, 32'h1 << OSSM_EVT_XTAL);
    end
  endtask

  task automatic t_fail;
    boot(OSSM_SRC_EXT, OSSM_EXT_LOGIC_LOW);
    wsrc(OSSM_SRC_EXT, 100);
    run <= 1'h0;
    wsrc(OSSM_SRC_HF_1M, 100);
    chk("ext enable", 32'h0, {31'h0, ext_en});
    rd("event", OSSM_OFS_EVT, 32'h1, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(OSSM_OFS_MASK, 32'h1, 2'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    axw(OSSM_OFS_EVT, 32'h1, 2'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd("event", OSSM_OFS_EVT, 32'h1, 32'h0);
  endtask

  // The crystal is held dead first, so a switch that ignores readiness shows.
  task automatic t_switch;
    run <= 1'h0;
    boot(OSSM_SRC_LF, OSSM_EXT_XTAL_MED);
    axw(OSSM_OFS_CTRL, 32'h3, 2'h0);
    repeat (30) @(posedge sys_clk);
    chk("held source", 32'h0, {29'h0, src});
    chk("ext enable", 32'h1, {31'h0, ext_en});
    run <= 1'h1;
    wsrc(OSSM_SRC_EXT, 100);
    rd("event", OSSM_OFS_EVT, 32'h2, 32'h2);
    axw(OSSM_OFS_CTRL, 32'h2, 2'h0);
    wsrc(OSSM_SRC_HF_32M, 50);
    ok <= 6'h1F;
    axw(OSSM_OFS_CTRL, 32'h1, 2'h0);
    repeat (20) @(posedge sys_clk);
    chk("held source", 32'h2, {29'h0, src});
    ok <= 6'h3F;
    wsrc(OSSM_SRC_HF_1M, 50);
  endtask

  initial begin
    {sys_clk, run, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rcs, logic_clock_medium_power, awaddr, araddr, wdata} = '0;
    sys_rst = 1'h1;
    ok = 6'h3F;
    errors = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    t_regs();
    t_boot_int();
    t_boot_ext();
    t_fail();
    t_switch();
    test_done();
  end

  initial begin
    #(1000000);
    errors++;
    test_done();
  end
endmodule
